// *** core/bcd_arith_pkg.sv ***
// Constants shared by the packed-decimal arithmetic unit and its divider.
// Assumes a 32-bit APB register bus with byte addresses.
package bcd_arith_pkg;

  // ------------------------------------------------------------
  // Widths
  // ------------------------------------------------------------
  localparam int unsigned DATA_W       = 32;
  localparam int unsigned ADDR_W       = 8;
  localparam int unsigned WORD_W       = 16;
  localparam int unsigned DWORD_W      = 32;
  localparam int unsigned DIGIT_W      = 4;
  localparam int unsigned DIGITS_WORD  = 4;
  localparam int unsigned DIGITS_DWORD = 8;
  localparam int unsigned BIN_W        = 27;

  // ------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------
  localparam logic [ADDR_W-1:0] CMD_OFS    = 8'h00;
  localparam logic [ADDR_W-1:0] OPA_LO_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] OPA_HI_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] OPB_LO_OFS = 8'h0c;
  localparam logic [ADDR_W-1:0] OPB_HI_OFS = 8'h10;
  localparam logic [ADDR_W-1:0] RES0_OFS   = 8'h14;
  localparam logic [ADDR_W-1:0] RES1_OFS   = 8'h18;
  localparam logic [ADDR_W-1:0] RES2_OFS   = 8'h1c;
  localparam logic [ADDR_W-1:0] RES3_OFS   = 8'h20;
  localparam logic [ADDR_W-1:0] FLAGS_OFS  = 8'h24;

  // ------------------------------------------------------------
  // Field positions and reset values
  // ------------------------------------------------------------
  localparam int unsigned CMD_OP_LSB     = 0;
  localparam int unsigned CMD_OP_W       = 4;
  localparam int unsigned CMD_EXEC_BIT   = 4;
  localparam int unsigned CMD_INDIR_BIT  = 5;
  localparam int unsigned FLAG_FAULT_BIT = 0;
  localparam int unsigned FLAG_CARRY_BIT = 1;
  localparam int unsigned FLAG_ZERO_BIT  = 2;
  localparam int unsigned FLAG_BUSY_BIT  = 3;
  localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;

  // ------------------------------------------------------------
  // Decimal arithmetic constants
  // ------------------------------------------------------------
  localparam logic [DIGIT_W-1:0]  DIGIT_MAX   = 4'h9;
  localparam logic [DIGIT_W:0]    DIGIT_ADJ   = 5'h06;
  localparam logic [DIGIT_W-1:0]  DABBLE_LIM  = 4'h5;
  localparam logic [DIGIT_W-1:0]  DABBLE_ADJ  = 4'h3;
  localparam logic [BIN_W-1:0]    RADIX       = 27'h000000a;
  localparam logic [DWORD_W-1:0]  INC_ADDEND  = 32'h0000_0001;
  localparam logic [DWORD_W-1:0]  DEC_ADDEND  = 32'h0000_9999;

  // ------------------------------------------------------------
  // Command codes
  // ------------------------------------------------------------
  typedef enum logic [CMD_OP_W-1:0] {
    OP_NOP              = 4'h0,
    OP_DECIMAL_DIVIDE   = 4'h1,
    OP_DECIMAL_LONG_DIVIDE = 4'h2,
    OP_DECIMAL_STEP_UP  = 4'h3,
    OP_DECIMAL_STEP_DOWN = 4'h4,
    OP_CARRY_FORCE_ONE  = 4'h5,
    OP_CARRY_FORCE_ZERO = 4'h6,
    OP_DECIMAL_SUM      = 4'h7,
    OP_DECIMAL_LONG_SUM = 4'h8,
    OP_END_OF_SCAN      = 4'h9
  } op_t;

endpackage

// *** core/bcd_bin_divider.sv ***
// Restoring binary divider, one quotient bit per clock.
// Assumes start is a one-cycle pulse given only while idle.
`timescale 1ns/1ps
`default_nettype none

module bcd_bin_divider #(
  parameter int unsigned W = bcd_arith_pkg::BIN_W
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic         start,
  input  wire logic [W-1:0] dividend,
  input  wire logic [W-1:0] divisor,
  output logic              done,
  output logic [W-1:0]      quotient,
  output logic [W-1:0]      remainder
);

  localparam int unsigned CW = $clog2(W + 1);

  logic [W-1:0]  div_reg;
  logic [W-1:0]  quo_reg;
  logic [W-1:0]  rem_reg;
  logic [CW-1:0] cnt_reg;
  logic          run_reg;
  logic          done_reg;
  logic [W:0]    trial;
  logic          fits;

  // ------------------------------------------------------------
  // Shift-subtract step
  // ------------------------------------------------------------
  always_comb begin
    trial = {rem_reg, quo_reg[W-1]};
    fits  = (trial >= {1'b0, div_reg});
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      div_reg <= '0;
      quo_reg <= '0;
      rem_reg <= '0;
    end else if (start) begin
      div_reg <= divisor;
      quo_reg <= dividend;
      rem_reg <= '0;
    end else if (run_reg) begin
      quo_reg <= {quo_reg[W-2:0], fits};
      if (fits) begin
        rem_reg <= W'(trial - {1'b0, div_reg});
      end else begin
        rem_reg <= trial[W-1:0];
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_reg  <= '0;
      run_reg  <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= run_reg && (cnt_reg == CW'(1));
      if (start) begin
        cnt_reg <= CW'(W);
        run_reg <= 1'b1;
      end else if (run_reg) begin
        cnt_reg <= cnt_reg - CW'(1);
        run_reg <= (cnt_reg != CW'(1));
      end
    end
  end

  assign done      = done_reg;
  assign quotient  = quo_reg;
  assign remainder = rem_reg;

endmodule

`default_nettype wire

// *** core/bcd_arith_unit.sv ***
// Packed-decimal arithmetic unit: divide, step, carry control and add.
// Assumes an APB master on clk; the sequencer loads operands, then
// writes a command word holding the code and the execution condition.
//
// Functional notes
// - Condition false: single divide does nothing, words and flags kept.
// - Single divide: quotient to result word, remainder to next word.
// - Double divide: 8-digit operands, quotient words 0-1, remainder 2-3.
// - Non-decimal divide operand sets fault, results kept.
// - Bad indirect address sets fault for every operation except carry force and end of scan.
// - Divide sets zero when the whole result is zero, else clears.
// - Step up and step down write back into the word read.
// - Other operations change only result words, sources kept.
// - Step up adds one in decimal, carry kept, bad word faults.
// - Step down subtracts one in decimal, carry kept.
// - Zero flag follows the stepped result.
// - Carry force one sets carry when enabled.
// - Carry force zero clears carry when enabled.
// - End of scan clears carry.
// - Single sum adds both words and carry, carry above 9999.
// - Non-decimal sum operand sets fault.
// - Sum updates carry from overflow and zero from stored result.
// - Double sum adds 8-digit pairs plus carry, carry above 99999999.
`timescale 1ns/1ps
`default_nettype none

module bcd_arith_unit #(
  parameter int unsigned ADDR_W = bcd_arith_pkg::ADDR_W,
  parameter int unsigned DATA_W = bcd_arith_pkg::DATA_W
) (
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  output logic [DATA_W-1:0]      prdata,
  output logic                   pready,
  output logic                   pslverr
);

  localparam int unsigned WW = bcd_arith_pkg::WORD_W;
  localparam int unsigned DW = bcd_arith_pkg::DWORD_W;
  localparam int unsigned BW = bcd_arith_pkg::BIN_W;
  localparam int unsigned GW = bcd_arith_pkg::DIGIT_W;

  typedef enum logic {ST_IDLE, ST_DIVIDE} unit_state_t;

  // ------------------------------------------------------------
  // Decimal helpers
  // ------------------------------------------------------------
  function automatic logic bcd_ok(input logic [DW-1:0] v);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < bcd_arith_pkg::DIGITS_DWORD; i++) begin
      if (v[i*GW +: GW] > bcd_arith_pkg::DIGIT_MAX) begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction

  // Ripple digit add over ndig digits; bit DW is the carry out
  function automatic logic [DW:0] bcd_add(input logic [DW-1:0] a,
                                          input logic [DW-1:0] b,
                                          input logic          cin,
                                          input int unsigned   ndig);
    logic [DW-1:0] s;
    logic          c;
    logic [GW:0]   d;
    s = '0;
    c = cin;
    for (int i = 0; i < bcd_arith_pkg::DIGITS_DWORD; i++) begin
      d = {1'b0, a[i*GW +: GW]} + {1'b0, b[i*GW +: GW]} + {{GW{1'b0}}, c};
      if (i < ndig) begin
        if (d > {1'b0, bcd_arith_pkg::DIGIT_MAX}) begin
          d = d + bcd_arith_pkg::DIGIT_ADJ;
          c = 1'b1;
        end else begin
          c = 1'b0;
        end
        s[i*GW +: GW] = d[GW-1:0];
      end
    end
    return {c, s};
  endfunction

  function automatic logic [BW-1:0] bcd_to_bin(input logic [DW-1:0] v);
    logic [BW-1:0] acc;
    acc = '0;
    for (int i = bcd_arith_pkg::DIGITS_DWORD - 1; i >= 0; i--) begin
      acc = BW'(acc * bcd_arith_pkg::RADIX) + BW'(v[i*GW +: GW]);
    end
    return acc;
  endfunction

  function automatic logic [DW-1:0] bin_to_bcd(input logic [BW-1:0] v);
    logic [DW-1:0] r;
    r = '0;
    for (int i = BW - 1; i >= 0; i--) begin
      for (int k = 0; k < bcd_arith_pkg::DIGITS_DWORD; k++) begin
        if (r[k*GW +: GW] >= bcd_arith_pkg::DABBLE_LIM) begin
          r[k*GW +: GW] = r[k*GW +: GW] + bcd_arith_pkg::DABBLE_ADJ;
        end
      end
      r = {r[DW-2:0], v[i]};
    end
    return r;
  endfunction

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  unit_state_t         state_reg;
  logic [WW-1:0]       opa_lo_reg;
  logic [WW-1:0]       opa_hi_reg;
  logic [WW-1:0]       opb_lo_reg;
  logic [WW-1:0]       opb_hi_reg;
  logic [WW-1:0]       res0_reg;
  logic [WW-1:0]       res1_reg;
  logic [WW-1:0]       res2_reg;
  logic [WW-1:0]       res3_reg;
  logic                fault_flag_reg;
  logic                carry_bit_reg;
  logic                zero_flag_reg;
  logic                long_div_reg;
  logic                ack_reg;
  logic [DATA_W-1:0]   prdata_reg;
  logic                pslverr_reg;

  logic                bus_go;
  logic                wr_go;
  logic                cmd_go;
  logic                run;
  bcd_arith_pkg::op_t  cmd_op;
  logic                cmd_indir;
  logic                is_long;
  logic [DW-1:0]       src_a;
  logic [DW-1:0]       src_b;
  logic [DW:0]         sum;
  logic [DW:0]         step;
  logic                bad_a;
  logic                bad_b;
  logic                err;
  logic                div_start;
  logic                div_done;
  logic [BW-1:0]       div_q;
  logic [BW-1:0]       div_r;
  logic [DW-1:0]       q_bcd;
  logic [DW-1:0]       r_bcd;
  logic [DATA_W-1:0]   rd_mux;
  logic                addr_ok;

  // ------------------------------------------------------------
  // APB slave: one wait state, stalls while a divide runs
  // ------------------------------------------------------------
  assign bus_go = psel && penable && ack_reg;
  assign wr_go  = bus_go && pwrite && addr_ok;
  assign cmd_go = wr_go && (paddr == bcd_arith_pkg::CMD_OFS);

  always_comb begin
    addr_ok = 1'b1;
    rd_mux  = '0;
    unique case (paddr)
      bcd_arith_pkg::CMD_OFS:    rd_mux = '0;
      bcd_arith_pkg::OPA_LO_OFS: rd_mux = DATA_W'(opa_lo_reg);
      bcd_arith_pkg::OPA_HI_OFS: rd_mux = DATA_W'(opa_hi_reg);
      bcd_arith_pkg::OPB_LO_OFS: rd_mux = DATA_W'(opb_lo_reg);
      bcd_arith_pkg::OPB_HI_OFS: rd_mux = DATA_W'(opb_hi_reg);
      bcd_arith_pkg::RES0_OFS:   rd_mux = DATA_W'(res0_reg);
      bcd_arith_pkg::RES1_OFS:   rd_mux = DATA_W'(res1_reg);
      bcd_arith_pkg::RES2_OFS:   rd_mux = DATA_W'(res2_reg);
      bcd_arith_pkg::RES3_OFS:   rd_mux = DATA_W'(res3_reg);
      bcd_arith_pkg::FLAGS_OFS: begin
        rd_mux[bcd_arith_pkg::FLAG_FAULT_BIT] = fault_flag_reg;
        rd_mux[bcd_arith_pkg::FLAG_CARRY_BIT] = carry_bit_reg;
        rd_mux[bcd_arith_pkg::FLAG_ZERO_BIT]  = zero_flag_reg;
        rd_mux[bcd_arith_pkg::FLAG_BUSY_BIT]  = (state_reg == ST_DIVIDE);
      end
      default: addr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ack_reg     <= 1'b0;
      prdata_reg  <= '0;
      pslverr_reg <= 1'b0;
    end else begin
      ack_reg <= psel && penable && !ack_reg && (state_reg == ST_IDLE);
      if (psel && penable && !ack_reg) begin
        prdata_reg  <= pwrite ? '0 : rd_mux;
        pslverr_reg <= !addr_ok;
      end
    end
  end

  assign prdata  = prdata_reg;
  assign pready  = ack_reg;
  assign pslverr = pslverr_reg;

  // ------------------------------------------------------------
  // Command decode and operand checks
  // ------------------------------------------------------------
  always_comb begin
    cmd_op    = bcd_arith_pkg::op_t'(pwdata[bcd_arith_pkg::CMD_OP_LSB +:
                                            bcd_arith_pkg::CMD_OP_W]);
    cmd_indir = pwdata[bcd_arith_pkg::CMD_INDIR_BIT];
    run       = cmd_go && pwdata[bcd_arith_pkg::CMD_EXEC_BIT];
    is_long   = (cmd_op == bcd_arith_pkg::OP_DECIMAL_LONG_DIVIDE) ||
                (cmd_op == bcd_arith_pkg::OP_DECIMAL_LONG_SUM);
    // Lower-addressed word holds the low digits
    src_a = is_long ? {opa_hi_reg, opa_lo_reg} : {{WW{1'b0}}, opa_lo_reg};
    src_b = is_long ? {opb_hi_reg, opb_lo_reg} : {{WW{1'b0}}, opb_lo_reg};
    bad_a = !bcd_ok(src_a);
    bad_b = !bcd_ok(src_b);
    sum   = bcd_add(src_a, src_b, carry_bit_reg,
                    is_long ? bcd_arith_pkg::DIGITS_DWORD : bcd_arith_pkg::DIGITS_WORD);
    if (cmd_op == bcd_arith_pkg::OP_DECIMAL_STEP_DOWN) begin
      step = bcd_add(src_a, bcd_arith_pkg::DEC_ADDEND, 1'b0,
                     bcd_arith_pkg::DIGITS_WORD);
    end else begin
      step = bcd_add(src_a, bcd_arith_pkg::INC_ADDEND, 1'b0,
                     bcd_arith_pkg::DIGITS_WORD);
    end
    err = cmd_indir;
    unique case (cmd_op)
      bcd_arith_pkg::OP_DECIMAL_DIVIDE,
      bcd_arith_pkg::OP_DECIMAL_LONG_DIVIDE:
        err = cmd_indir || bad_a || bad_b || (src_b == '0);
      bcd_arith_pkg::OP_DECIMAL_SUM,
      bcd_arith_pkg::OP_DECIMAL_LONG_SUM:
        err = cmd_indir || bad_a || bad_b;
      bcd_arith_pkg::OP_DECIMAL_STEP_UP,
      bcd_arith_pkg::OP_DECIMAL_STEP_DOWN:
        err = cmd_indir || bad_a;
      default: err = cmd_indir;
    endcase
    div_start = run && !err &&
                ((cmd_op == bcd_arith_pkg::OP_DECIMAL_DIVIDE) ||
                 (cmd_op == bcd_arith_pkg::OP_DECIMAL_LONG_DIVIDE));
  end

  // ------------------------------------------------------------
  // Divider and its control
  // ------------------------------------------------------------
  bcd_bin_divider #(
    .W (BW)
  ) u_divider (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .start     (div_start),
    .dividend  (bcd_to_bin(src_a)),
    .divisor   (bcd_to_bin(src_b)),
    .done      (div_done),
    .quotient  (div_q),
    .remainder (div_r)
  );

  assign q_bcd = bin_to_bcd(div_q);
  assign r_bcd = bin_to_bcd(div_r);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg    <= ST_IDLE;
      long_div_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (div_start) begin
            state_reg    <= ST_DIVIDE;
            long_div_reg <= is_long;
          end
        end
        ST_DIVIDE: begin
          if (div_done) begin
            state_reg <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Operand words: software writes, stepped word written back
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      opa_lo_reg <= bcd_arith_pkg::WORD_RST;
      opa_hi_reg <= bcd_arith_pkg::WORD_RST;
      opb_lo_reg <= bcd_arith_pkg::WORD_RST;
      opb_hi_reg <= bcd_arith_pkg::WORD_RST;
    end else if (run && !err &&
                 ((cmd_op == bcd_arith_pkg::OP_DECIMAL_STEP_UP) ||
                  (cmd_op == bcd_arith_pkg::OP_DECIMAL_STEP_DOWN))) begin
      opa_lo_reg <= step[WW-1:0];
    end else if (wr_go) begin
      if (paddr == bcd_arith_pkg::OPA_LO_OFS) opa_lo_reg <= pwdata[WW-1:0];
      if (paddr == bcd_arith_pkg::OPA_HI_OFS) opa_hi_reg <= pwdata[WW-1:0];
      if (paddr == bcd_arith_pkg::OPB_LO_OFS) opb_lo_reg <= pwdata[WW-1:0];
      if (paddr == bcd_arith_pkg::OPB_HI_OFS) opb_hi_reg <= pwdata[WW-1:0];
    end
  end

  // ------------------------------------------------------------
  // Result words: only these change for sums and divides
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      res0_reg <= bcd_arith_pkg::WORD_RST;
      res1_reg <= bcd_arith_pkg::WORD_RST;
      res2_reg <= bcd_arith_pkg::WORD_RST;
      res3_reg <= bcd_arith_pkg::WORD_RST;
    end else if (state_reg == ST_DIVIDE && div_done) begin
      if (long_div_reg) begin
        res0_reg <= q_bcd[WW-1:0];
        res1_reg <= q_bcd[DW-1:WW];
        res2_reg <= r_bcd[WW-1:0];
        res3_reg <= r_bcd[DW-1:WW];
      end else begin
        res0_reg <= q_bcd[WW-1:0];
        res1_reg <= r_bcd[WW-1:0];
      end
    end else if (run && !err) begin
      if (cmd_op == bcd_arith_pkg::OP_DECIMAL_SUM) begin
        res0_reg <= sum[WW-1:0];
      end else if (cmd_op == bcd_arith_pkg::OP_DECIMAL_LONG_SUM) begin
        res0_reg <= sum[WW-1:0];
        res1_reg <= sum[DW-1:WW];
      end
    end
  end

  // ------------------------------------------------------------
  // Flags
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fault_flag_reg <= 1'b0;
      carry_bit_reg  <= 1'b0;
      zero_flag_reg  <= 1'b0;
    end else if (state_reg == ST_DIVIDE && div_done) begin
      fault_flag_reg <= 1'b0;
      zero_flag_reg  <= (q_bcd == '0) && (r_bcd == '0);
    end else if (cmd_go && cmd_op == bcd_arith_pkg::OP_END_OF_SCAN) begin
      carry_bit_reg <= 1'b0;
    end else if (run) begin
      unique case (cmd_op)
        bcd_arith_pkg::OP_CARRY_FORCE_ONE:  carry_bit_reg <= 1'b1;
        bcd_arith_pkg::OP_CARRY_FORCE_ZERO: carry_bit_reg <= 1'b0;
        bcd_arith_pkg::OP_DECIMAL_STEP_UP,
        bcd_arith_pkg::OP_DECIMAL_STEP_DOWN: begin
          fault_flag_reg <= err;
          if (!err) begin
            zero_flag_reg <= (step[WW-1:0] == '0);
          end
        end
        bcd_arith_pkg::OP_DECIMAL_SUM: begin
          fault_flag_reg <= err;
          if (!err) begin
            carry_bit_reg <= sum[DW];
            zero_flag_reg <= (sum[WW-1:0] == '0);
          end
        end
        bcd_arith_pkg::OP_DECIMAL_LONG_SUM: begin
          fault_flag_reg <= err;
          if (!err) begin
            carry_bit_reg <= sum[DW];
            zero_flag_reg <= (sum[DW-1:0] == '0);
          end
        end
        bcd_arith_pkg::OP_DECIMAL_DIVIDE,
        bcd_arith_pkg::OP_DECIMAL_LONG_DIVIDE: begin
          if (err) begin
            fault_flag_reg <= 1'b1;
          end
        end
        default: begin
          if (err) begin
            fault_flag_reg <= 1'b1;
          end
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// *** verification/seq_master.sv ***
// APB master standing in for the instruction sequencer.
// Assumes one clock; the bench calls xfer right after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module seq_master (
  input  wire logic        clk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0000_0000;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // Released data no longer holds its value
    pwdata  <= ~d;
  endtask
endmodule
`default_nettype wire

// *** verification/bcd_arith_monitor.sv ***
// Checker on the unit's APB ports: flag and stepped operand results after commands.
// Assumes it is bound to bcd_arith_unit.
`timescale 1ns/1ps
`default_nettype none
module bcd_arith_monitor #(
  parameter int unsigned ADDR_W = bcd_arith_pkg::ADDR_W,
  parameter int unsigned DATA_W = bcd_arith_pkg::DATA_W
) (
  input wire logic              clk,
  input wire logic              sys_rst,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [DATA_W-1:0] prdata,
  input wire logic              pready,
  input wire logic              pslverr
);
  logic [5:0]  lc;
  logic [15:0] wa;
  logic [15:0] wb;
  wire ok = psel && penable && pready;
  wire rf = ok && !pwrite && paddr == bcd_arith_pkg::FLAGS_OFS;
  wire ra = ok && !pwrite && paddr == bcd_arith_pkg::OPA_LO_OFS;
  function automatic logic bad(input logic [15:0] x);
    return x[3:0] > 4'h9 || x[7:4] > 4'h9 || x[11:8] > 4'h9 || x[15:12] > 4'h9;
  endfunction
  // Last command, forgotten once any operand is rewritten
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      lc <= 6'h00;
      wa <= 16'h0000;
      wb <= 16'h0000;
    end else if (ok && pwrite) begin
      lc <= (paddr == bcd_arith_pkg::CMD_OFS) ? pwdata[5:0] : 6'h00;
      if (paddr == bcd_arith_pkg::OPA_LO_OFS) wa <= pwdata[15:0];
      if (paddr == bcd_arith_pkg::OPB_LO_OFS) wb <= pwdata[15:0];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_force_one: assert property (rf && lc[4:0] == 5'h15 |-> prdata[1])
    else $error("carry not set");
  a_force_zero: assert property (rf && lc[4:0] == 5'h16 |-> !prdata[1])
    else $error("carry not cleared");
  a_scan_clear: assert property (rf && lc[3:0] == 4'h9 |-> !prdata[1])
    else $error("carry kept at end of scan");
  a_indir_fault: assert property (rf && lc[5:4] == 2'b11 &&
    lc[3:0] inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h7, 4'h8} |-> prdata[0])
    else $error("indirect fault missed");
  a_wrap_up: assert property (ra && lc == 6'h13 && wa == 16'h9999 |-> prdata[15:0] == 16'h0000)
    else $error("step up wrong");
  a_wrap_down: assert property (ra && lc == 6'h14 && wa == 16'h0000 |-> prdata[15:0] == 16'h9999)
    else $error("step down wrong");
  a_step_zero: assert property (rf && lc == 6'h13 && wa == 16'h9999 |-> prdata[2] && !prdata[0])
    else $error("zero flag after step wrong");
  a_bad_div: assert property (rf && lc == 6'h11 && bad(wa) |-> prdata[0])
    else $error("bad dividend not faulted");
  a_zero_div: assert property (rf && lc == 6'h11 && wb == 16'h0000 |-> prdata[0])
    else $error("zero divisor not faulted");
  a_bad_sum: assert property (rf && lc == 6'h17 && (bad(wa) || bad(wb)) |-> prdata[0])
    else $error("bad sum operand not faulted");
  c_div: cover property (ok && pwrite && paddr == bcd_arith_pkg::CMD_OFS && pwdata[3:0] == 4'h1);
  c_lsum: cover property (ok && pwrite && paddr == bcd_arith_pkg::CMD_OFS && pwdata[3:0] == 4'h8);
  c_fault: cover property (rf && prdata[0]);
endmodule
bind bcd_arith_unit bcd_arith_monitor #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_mon (
  .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
`default_nettype wire

// *** verification/bcd_arith_unit_tb.sv ***
// Self-checking bench for the packed-decimal unit over APB.
// Assumes seq_master drives the bus and the monitor is bound.
`timescale 1ns/1ps
`default_nettype none
module bcd_arith_unit_tb;
  logic        clk, sys_rst, psel, penable, pwrite, pready, pslverr, se;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rv;
  int          err_total, compares, cyc;
  bcd_arith_unit DUT (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  seq_master m (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  task automatic report_and_stop;
    if (err_total == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    m.xfer(1'b1, a, {16'h0000, d}, rv, se);
  endtask
  task automatic rd(input logic [7:0] a);
    m.xfer(1'b0, a, 32'h0000_0000, rv, se);
  endtask
  task automatic cmd(input logic [7:0] c);
    wr(bcd_arith_pkg::CMD_OFS, {8'h00, c});
  endtask
  task automatic op(input logic [15:0] al, ah, bl, bh, input logic [7:0] c);
    wr(bcd_arith_pkg::OPA_LO_OFS, al);
    wr(bcd_arith_pkg::OPA_HI_OFS, ah);
    wr(bcd_arith_pkg::OPB_LO_OFS, bl);
    wr(bcd_arith_pkg::OPB_HI_OFS, bh);
    cmd(c);
  endtask
  task automatic rres(input logic [15:0] e0, e1, e2, e3);
    rd(bcd_arith_pkg::RES0_OFS);
    cmp("res0", e0, rv[15:0]);
    rd(bcd_arith_pkg::RES1_OFS);
    cmp("res1", e1, rv[15:0]);
    rd(bcd_arith_pkg::RES2_OFS);
    cmp("res2", e2, rv[15:0]);
    rd(bcd_arith_pkg::RES3_OFS);
    cmp("res3", e3, rv[15:0]);
  endtask
  task automatic rfl(input logic [3:0] e);
    rd(bcd_arith_pkg::FLAGS_OFS);
    cmp("flags", {12'h000, e}, {12'h000, rv[3:0]});
  endtask
  task automatic ra(input logic [15:0] e);
    rd(bcd_arith_pkg::OPA_LO_OFS);
    cmp("opa", e, rv[15:0]);
  endtask
  // ----------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------
  task automatic t_div;
    op(16'h0100, 16'h0000, 16'h0007, 16'h0000, 8'h11);
    rres(16'h0014, 16'h0002, 16'h0000, 16'h0000);
    rfl(4'h0);
    ra(16'h0100);
    op(16'h0200, 16'h0000, 16'h0003, 16'h0000, 8'h01);
    rres(16'h0014, 16'h0002, 16'h0000, 16'h0000);
    op(16'h0000, 16'h0000, 16'h0005, 16'h0000, 8'h11);
    rfl(4'h4);
  endtask
  task automatic t_ldiv;
    op(16'h5678, 16'h1234, 16'h1000, 16'h0000, 8'h12);
    rres(16'h2345, 16'h0001, 16'h0678, 16'h0000);
    op(16'h00a0, 16'h0000, 16'h0003, 16'h0000, 8'h11);
    rfl(4'h1);
    op(16'h0100, 16'h0000, 16'h0000, 16'h0000, 8'h11);
    rfl(4'h1);
    op(16'h0000, 16'h00b0, 16'h0001, 16'h0000, 8'h12);
    rres(16'h2345, 16'h0001, 16'h0678, 16'h0000);
  endtask
  task automatic t_sum;
    cmd(8'h16);
    op(16'h9999, 16'h0000, 16'h0001, 16'h0000, 8'h17);
    rfl(4'h6);
    op(16'h0001, 16'h0000, 16'h0002, 16'h0000, 8'h17);
    rres(16'h0004, 16'h0001, 16'h0678, 16'h0000);
    op(16'h9999, 16'h9999, 16'h0001, 16'h0000, 8'h18);
    rres(16'h0000, 16'h0000, 16'h0678, 16'h0000);
    rfl(4'h6);
    op(16'h00c0, 16'h0000, 16'h0001, 16'h0000, 8'h17);
    rfl(4'h7);
    op(16'h0001, 16'h0000, 16'h0001, 16'h0000, 8'h37);
    rfl(4'h7);
  endtask
  task automatic t_carry;
    op(16'h0001, 16'h0000, 16'h0001, 16'h0000, 8'h17);
    rfl(4'h0);
    cmd(8'h05);
    rfl(4'h0);
    cmd(8'h15);
    rfl(4'h2);
    cmd(8'h06);
    rfl(4'h2);
    cmd(8'h16);
    rfl(4'h0);
    cmd(8'h15);
    cmd(8'h09);
    rfl(4'h0);
  endtask
  task automatic t_step;
    cmd(8'h15);
    op(16'h9999, 16'h0000, 16'h0000, 16'h0000, 8'h13);
    ra(16'h0000);
    rfl(4'h6);
    op(16'h0000, 16'h0000, 16'h0000, 16'h0000, 8'h14);
    ra(16'h9999);
    rfl(4'h2);
    op(16'h00f0, 16'h0000, 16'h0000, 16'h0000, 8'h13);
    rfl(4'h3);
    rd(8'h40);
    cmp("slverr", 16'h0001, {15'h0000, se});
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total++;
      report_and_stop;
    end
  end
  initial begin
    sys_rst   = 1'b1;
    err_total = 0;
    compares  = 0;
    cyc       = 0;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    t_div;
    t_ldiv;
    t_sum;
    t_carry;
    t_step;
    report_and_stop;
  end
endmodule
`default_nettype wire
